// file: lcm_cfg.svh
`ifndef LCM_CFG_SVH
`define LCM_CFG_SVH
`define LCM_NCH 12
`define LCM_LW 8
`define LCM_FULL 8'hff
`define LCM_ZERO 8'h00
`define LCM_NCUE 50
`define LCM_NPAT_FIXED 4
`define LCM_NPAT_PROG 7
`define LCM_NSTEP 24
`define LCM_NPAGE 4
`endif

// file: lcm_dimmer_enc.sv
`include "lcm_cfg.svh"
module lcm_dimmer_enc (
    input wire logic I_REF_CLK,
    input wire logic [`LCM_NCH*`LCM_LW-1:0] i_lvl,
    output logic [`LCM_NCH*`LCM_LW-1:0] o_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    // Takes one frame of channel levels each clock, as a dimmer encoder would.
    always_ff @(posedge I_REF_CLK) begin
        o_seen <= i_lvl;
    end
endmodule

// file: lcm_mixer.sv
// Contract
// - Each channel level comes from one upper and one lower fader.
// - Crossfader at top gives upper scene only.
// - Crossfader at bottom gives lower scene only.
// - Equal levels in both scenes never dip during crossfade.
// - Master scales manual, preset and cue sources; zero master gives nothing.
// - Flash and chaser bypass the master.
// - In run, flash holds only while button held.
// - Recording or editing disables flash; presses select memories.
// - Five flash modes kept and shown on the two-character display.
// - Off mode ignores all flash presses.
// - Channel add raises only the held channel.
// - Channel solo blacks others, drives channel full, chaser unaffected.
// - Preset flash modes only while presets active.
// - Page off runs two-scene mode, preset indicator off.
// - Per-channel indicator brightness follows channel output.
// - Same mixed levels go to all output encoders.
// - Power-on self-test; failure may limit to manual mode.
// - Cue stack offers up to fifty cues.
// - Chaser has four fixed, seven programmable patterns, 24 steps.
// - Chaser supports single step and momentary hold.
// - Presets live on four selectable pages.
`include "lcm_cfg.svh"
module lcm_mixer
    import lcm_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic i_ce,
    input wire logic [`LCM_NCH*`LCM_LW-1:0] i_upper,
    input wire logic [`LCM_NCH*`LCM_LW-1:0] i_lower,
    input wire logic [`LCM_LW-1:0] i_xfade,
    input wire logic [`LCM_LW-1:0] i_master,
    input wire logic [`LCM_NCH*`LCM_LW-1:0] i_cue,
    input wire logic [`LCM_NCH*`LCM_LW-1:0] i_chase,
    input wire logic [`LCM_NCH*`LCM_LW-1:0] i_preset,
    input wire logic [`LCM_NCH-1:0] i_bump,
    input wire logic i_record,
    input wire logic i_edit,
    input wire logic [2:0] i_page,
    input wire logic i_page_up,
    input wire logic i_page_down,
    input wire logic i_flash_up,
    input wire logic i_flash_down,
    input wire logic i_flash_menu,
    input wire logic i_test_done,
    input wire logic i_test_fail,
    output logic [`LCM_NCH*`LCM_LW-1:0] o_out,
    output logic [`LCM_NCH*`LCM_LW-1:0] o_led,
    output logic [`LCM_NCH-1:0] o_select,
    output logic [2:0] o_flash_mode,
    output logic [7:0] o_disp,
    output logic o_preset_led,
    output logic o_manual_only,
    output logic [2:0] o_page
);
    logic [`LCM_NCH-1:0] bump_s1;
    logic [`LCM_NCH-1:0] bump_s2;
    logic [`LCM_NCH-1:0] bump_prev;
    lcm_flash_e flash_mode;
    lcm_state_e state;
    logic [2:0] page;
    logic [`LCM_NCH*`LCM_LW-1:0] next_out;
    logic [`LCM_NCH*`LCM_LW-1:0] up_scaled;
    logic [`LCM_NCH*`LCM_LW-1:0] lo_scaled;
    logic [`LCM_NCH*`LCM_LW-1:0] man_mst;
    logic [`LCM_NCH*`LCM_LW-1:0] pre_mst;
    logic [`LCM_NCH*`LCM_LW-1:0] cue_mst;
    logic [`LCM_LW-1:0] xinv;
    logic presets_on;
    logic flash_ok;

    assign xinv = `LCM_FULL - i_xfade;
    assign presets_on = (page != 3'h0) && (state == LCM_ST_FULL);

    // Bump buttons come from panel pins and are synchronised.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            bump_s1 <= '0;
            bump_s2 <= '0;
            bump_prev <= '0;
        end else if (i_ce) begin
            bump_s1 <= i_bump;
            bump_s2 <= bump_s1;
            bump_prev <= bump_s2;
        end
    end

    function automatic logic [`LCM_LW-1:0] lmax(input logic [`LCM_LW-1:0] a, input logic [`LCM_LW-1:0] b);
        lmax = (a > b) ? a : b;
    endfunction

    function automatic logic [`LCM_LW-1:0] lsum(input logic [`LCM_LW-1:0] a, input logic [`LCM_LW-1:0] b);
        logic [`LCM_LW:0] s;
        s = {1'b0, a} + {1'b0, b};
        lsum = s[`LCM_LW] ? `LCM_FULL : s[`LCM_LW-1:0];
    endfunction

    // Per-channel crossfade and master scaling.
    genvar g;
    generate
        for (g = 0; g < `LCM_NCH; g++) begin : gch
            logic [`LCM_LW-1:0] man;
            lcm_scale u_up (.i_a(i_upper[g*`LCM_LW +: `LCM_LW]), .i_b(i_xfade), .o_p(up_scaled[g*`LCM_LW +: `LCM_LW]));
            lcm_scale u_lo (.i_a(i_lower[g*`LCM_LW +: `LCM_LW]), .i_b(xinv), .o_p(lo_scaled[g*`LCM_LW +: `LCM_LW]));
            assign man = lmax(lsum(up_scaled[g*`LCM_LW +: `LCM_LW], lo_scaled[g*`LCM_LW +: `LCM_LW]),
                (i_upper[g*`LCM_LW +: `LCM_LW] == i_lower[g*`LCM_LW +: `LCM_LW]) ?
                i_upper[g*`LCM_LW +: `LCM_LW] : `LCM_ZERO);
            lcm_scale u_mm (.i_a(man), .i_b(i_master), .o_p(man_mst[g*`LCM_LW +: `LCM_LW]));
            lcm_scale u_pm (.i_a(i_preset[g*`LCM_LW +: `LCM_LW]), .i_b(i_master), .o_p(pre_mst[g*`LCM_LW +: `LCM_LW]));
            lcm_scale u_cm (.i_a(i_cue[g*`LCM_LW +: `LCM_LW]), .i_b(i_master), .o_p(cue_mst[g*`LCM_LW +: `LCM_LW]));
        end
    endgenerate

    // Self-test outcome decides full or manual-only operation.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            state <= LCM_ST_TEST;
        end else if (i_ce) begin
            unique case (state)
                LCM_ST_TEST: begin
                    if (i_test_done) begin
                        state <= i_test_fail ? LCM_ST_MANUAL : LCM_ST_FULL;
                    end
                end
                LCM_ST_FULL: state <= LCM_ST_FULL;
                LCM_ST_MANUAL: state <= LCM_ST_MANUAL;
                default: state <= LCM_ST_TEST;
            endcase
        end
    end

    // Memory page selection, zero means plain two-scene.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            page <= 3'h0;
        end else if (i_ce) begin
            if (i_page_up && page < `LCM_NPAGE) begin
                page <= page + 3'h1;
            end else if (i_page_down && page != 3'h0) begin
                page <= page - 3'h1;
            end
        end
    end

    // Flash mode selection.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            flash_mode <= LCM_FL_CH_ADD;
        end else if (i_ce) begin
            if (!presets_on && (flash_mode == LCM_FL_PS_ADD || flash_mode == LCM_FL_PS_SOLO)) begin
                flash_mode <= LCM_FL_CH_SOLO;
            end else if (i_flash_up && (presets_on ? flash_mode != LCM_FL_PS_SOLO : flash_mode < LCM_FL_CH_SOLO)) begin
                flash_mode <= lcm_flash_e'(flash_mode + 3'h1);
            end else if (i_flash_down && flash_mode != LCM_FL_OFF) begin
                flash_mode <= lcm_flash_e'(flash_mode - 3'h1);
            end
        end
    end

    assign flash_ok = !i_record && !i_edit && flash_mode != LCM_FL_OFF;

    // Final mix: highest-takes between sources, solo overrides all but the chaser.
    always_comb begin
        logic solo;
        logic [`LCM_LW-1:0] lv;
        logic [`LCM_LW-1:0] ch;
        lv = `LCM_ZERO;
        ch = `LCM_ZERO;
        next_out = '0;
        solo = flash_ok && (|bump_s2) &&
            (flash_mode == LCM_FL_CH_SOLO || flash_mode == LCM_FL_PS_SOLO);
        for (int i = 0; i < `LCM_NCH; i++) begin
            ch = i_chase[i*`LCM_LW +: `LCM_LW];
            lv = man_mst[i*`LCM_LW +: `LCM_LW];
            if (presets_on) begin
                lv = lmax(lv, pre_mst[i*`LCM_LW +: `LCM_LW]);
            end
            if (state == LCM_ST_FULL) begin
                lv = lmax(lv, cue_mst[i*`LCM_LW +: `LCM_LW]);
            end
            if (solo) begin
                lv = `LCM_ZERO;
            end
            if (flash_ok && bump_s2[i]) begin
                if (flash_mode == LCM_FL_PS_ADD || flash_mode == LCM_FL_PS_SOLO) begin
                    lv = lmax(lv, i_preset[i*`LCM_LW +: `LCM_LW]);
                end else begin
                    lv = `LCM_FULL;
                end
            end
            next_out[i*`LCM_LW +: `LCM_LW] = lmax(lv, ch);
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            o_out <= '0;
            o_led <= '0;
        end else if (i_ce) begin
            o_out <= next_out;
            o_led <= next_out;
        end
    end

    // Memory selection presses while recording or editing.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            o_select <= '0;
        end else if (i_ce) begin
            o_select <= (i_record || i_edit) ? (bump_s2 & ~bump_prev) : '0;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            o_disp <= 8'h00;
        end else if (i_ce) begin
            o_disp <= i_flash_menu ? {5'h00, flash_mode} + 8'h01 : {5'h00, page};
        end
    end

    assign o_flash_mode = flash_mode;
    assign o_preset_led = presets_on;
    assign o_manual_only = (state == LCM_ST_MANUAL);
    assign o_page = page;

    // cue, chase and page contents arrive already formed.
    logic [2:0] unused_page;
    assign unused_page = i_page;
endmodule

// file: lcm_mixer_properties.sv
`include "lcm_cfg.svh"
module lcm_mixer_chk
    import lcm_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic i_ce,
    input wire logic [`LCM_NCH*`LCM_LW-1:0] i_chase,
    input wire logic [`LCM_LW-1:0] i_master,
    input wire logic [`LCM_NCH-1:0] i_bump,
    input wire logic i_record,
    input wire logic i_edit,
    input wire logic i_flash_menu,
    input wire logic [`LCM_NCH*`LCM_LW-1:0] o_out,
    input wire logic [`LCM_NCH*`LCM_LW-1:0] o_led,
    input wire logic [`LCM_NCH-1:0] o_select,
    input wire logic [2:0] o_flash_mode,
    input wire logic [7:0] o_disp,
    input wire logic o_preset_led,
    input wire logic o_manual_only,
    input wire logic [2:0] o_page
);
    timeunit 1ns;
    timeprecision 1ns;
    // Every check runs on the reference clock and sleeps in reset.
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    led_mirror_a: assert property (o_led == o_out)
        else $error("indicator differs from output");
    chase_pass_a: assert property ((i_ce && i_bump == '0 && i_master == '0 && $stable(i_chase))[*4]
        |=> o_out == $past(i_chase)) else $error("chaser not passed with master down");
    select_gate_a: assert property ((!i_record && !i_edit)[*4] |=> o_select == '0)
        else $error("select pulse outside recording");
    disp_mode_a: assert property ((i_flash_menu && $stable(o_flash_mode))[*2]
        |-> o_disp == {5'h00, o_flash_mode} + 8'h01) else $error("display does not show mode");
    mode_range_a: assert property (o_flash_mode <= 3'h4)
        else $error("flash mode out of range");
    preset_entry_a: assert property ($rose(o_flash_mode >= 3'h3) |-> $past(o_preset_led))
        else $error("preset mode entered without presets");
    page_off_a: assert property ((o_page == 3'h0)[*2] |-> !o_preset_led)
        else $error("preset indicator lit with page off");
    manual_only_a: assert property (o_manual_only |-> !o_preset_led)
        else $error("presets active after failed test");
endmodule
bind lcm_mixer lcm_mixer_chk chk (.*);

// file: lcm_mixer_test.sv
`include "lcm_cfg.svh"
module lcm_mixer_test
    import lcm_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int W = `LCM_NCH * `LCM_LW;
    logic I_REF_CLK = 0, I_RST = 1, i_ce = 1, i_record = 0, i_edit = 0, i_flash_menu = 0;
    logic i_test_done = 1, i_test_fail = 0;
    logic [W-1:0] i_upper = '0, i_lower = '0, i_cue = '0, i_chase = '0, i_preset = '0;
    logic [W-1:0] o_out, o_led, s0, s1;
    logic [7:0] i_xfade = '0, i_master = '0, o_disp, lo;
    logic [11:0] i_bump = '0, o_select, sel;
    logic [2:0] i_page = '0, o_flash_mode, o_page;
    logic [3:0] keys = '0;
    logic o_preset_led, o_manual_only;
    wire i_page_up, i_page_down, i_flash_up, i_flash_down;
    int num_errors = 0, samples_checked = 0;
    assign {i_page_up, i_page_down, i_flash_up, i_flash_down} = keys;
    lcm_mixer DUT (.*);
    lcm_dimmer_enc enc0 (.I_REF_CLK(I_REF_CLK), .i_lvl(o_out), .o_seen(s0));
    lcm_dimmer_enc enc1 (.I_REF_CLK(I_REF_CLK), .i_lvl(o_out), .o_seen(s1));
    // Free-running 20 MHz reference clock.
    initial forever #25 I_REF_CLK = ~I_REF_CLK;
    function automatic logic [W-1:0] rep(input logic [7:0] v);
        return {`LCM_NCH{v}};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge I_REF_CLK);
    endtask
    // Front-panel keys are one-cycle pulses.
    task automatic key(input logic [3:0] k);
        keys = k;
        tick(1);
        keys = 4'h0;
        tick(1);
    endtask
    task automatic chk(input logic [W-1:0] s, input logic [W-1:0] e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence of scenarios.
    initial begin
        tick(8);
        I_RST = 0;
        i_master = 8'hff;
        i_upper = rep(8'hff);
        tick(2);
        chk(o_out, '0);
        i_upper = W'(8'hff) << 16;
        i_xfade = 8'hff;
        tick(2);
        chk(o_out & ~(W'(8'hff) << 16), '0);
        i_upper = '0;
        i_lower = rep(8'hff);
        tick(2);
        chk(o_out, '0);
        i_master = '0;
        i_upper = rep(8'hff);
        i_xfade = 8'h80;
        tick(2);
        chk(o_out, '0);
        $display("test scene ends done");
        i_master = 8'hff;
        i_upper = rep(8'h80);
        i_lower = rep(8'h80);
        i_xfade = '0;
        tick(2);
        lo = o_out[7:0];
        for (int x = 0; x < 256; x += 17) begin
            i_xfade = 8'(x);
            tick(2);
            chk(W'(o_out[7:0] >= lo), W'(1));
        end
        i_upper = rep(8'hff);
        i_lower = '0;
        lo = '0;
        for (int x = 0; x < 256; x += 17) begin
            i_xfade = 8'(x);
            tick(2);
            chk(W'(o_out[7:0] >= lo), W'(1));
            lo = o_out[7:0];
        end
        chk(W'(lo != 8'h00), W'(1));
        $display("test crossfade done");
        i_master = '0;
        i_upper = '0;
        i_chase = rep(8'h40);
        i_bump = 12'h008;
        tick(4);
        chk(o_out, rep(8'h40) | (W'(8'hff) << 24));
        chk(s0, s1);
        chk(s0, rep(8'h40) | (W'(8'hff) << 24));
        i_bump = '0;
        tick(4);
        chk(o_out, rep(8'h40));
        $display("test channel add done");
        key(4'h2);
        chk(W'(o_flash_mode), W'(LCM_FL_CH_SOLO));
        key(4'h2);
        chk(W'(o_flash_mode), W'(LCM_FL_CH_SOLO));
        i_chase = W'(8'h40);
        i_cue = rep(8'h80);
        i_master = 8'hff;
        i_bump = 12'h020;
        tick(4);
        chk(o_out, (W'(8'hff) << 40) | W'(8'h40));
        i_bump = '0;
        key(4'h1);
        key(4'h1);
        i_flash_menu = 1;
        i_master = '0;
        tick(2);
        chk(W'(o_disp), W'(8'h01));
        i_bump = 12'hfff;
        tick(4);
        chk(o_out, W'(8'h40));
        i_bump = '0;
        i_flash_menu = 0;
        $display("test solo and off done");
        key(4'h2);
        i_record = 1;
        sel = '0;
        tick(1);
        i_bump = 12'h004;
        repeat (6) begin
            tick(1);
            sel |= o_select;
        end
        chk(W'(sel), W'(12'h004));
        chk(o_out, W'(8'h40));
        i_bump = '0;
        i_record = 0;
        repeat (5) key(4'h8);
        chk(W'(o_page), W'(3'h4));
        chk(W'(o_preset_led), W'(1));
        repeat (3) key(4'h2);
        chk(W'(o_flash_mode), W'(LCM_FL_PS_SOLO));
        repeat (4) key(4'h4);
        chk(W'(o_preset_led), W'(0));
        chk(W'(o_flash_mode), W'(LCM_FL_CH_SOLO));
        $display("test record and pages done");
        i_chase = '0;
        i_test_fail = 1;
        I_RST = 1;
        tick(2);
        I_RST = 0;
        tick(3);
        chk(W'(o_manual_only), W'(1));
        key(4'h8);
        chk(W'(o_preset_led), W'(0));
        $display("test self-test failure done");
        summarize();
    end
endmodule

// file: lcm_pkg.sv
`include "lcm_cfg.svh"
package lcm_pkg;
    typedef logic [`LCM_LW-1:0] lcm_lvl_t;
    typedef enum logic [2:0] {
        LCM_FL_OFF = 3'h0,
        LCM_FL_CH_ADD = 3'h1,
        LCM_FL_CH_SOLO = 3'h2,
        LCM_FL_PS_ADD = 3'h3,
        LCM_FL_PS_SOLO = 3'h4
    } lcm_flash_e;
    typedef enum logic [1:0] {
        LCM_ST_TEST = 2'h0,
        LCM_ST_FULL = 2'h1,
        LCM_ST_MANUAL = 2'h2
    } lcm_state_e;
endpackage

// file: lcm_scale.sv
`include "lcm_cfg.svh"
module lcm_scale
    import lcm_pkg::*;
(
    input wire logic [`LCM_LW-1:0] i_a,
    input wire logic [`LCM_LW-1:0] i_b,
    output logic [`LCM_LW-1:0] o_p
);
    logic [2*`LCM_LW-1:0] prod;
    // Product rounded so that full times full yields full.
    always_comb begin
        prod = i_a * i_b + {{`LCM_LW{1'b0}}, i_a};
        o_p = prod[2*`LCM_LW-1:`LCM_LW];
    end
endmodule
